// File: logic/dcps_top.sv
// device configuration register bank and shared-pin owner logic
// assumes an APB master on pclk; all pin inputs are asynchronous
`timescale 1ns/1ps
module dcps_top #(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int MUTE_SRCS = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // boot strap pins
  input wire logic ext_reset_n,
  input wire logic [7:0] boot_pins_a,
  input wire logic [7:0] boot_pins_b,
  // shared pins
  input wire logic [dcps_pkg::NUM_PINS-1:0] shared_pin_i,
  output logic [dcps_pkg::NUM_PINS-1:0] shared_pin_o,
  output logic [dcps_pkg::NUM_PINS-1:0] shared_pin_oe,
  // serial port zero: out, in, clock, chip select, enable
  input wire logic [4:0] serial0_out,
  input wire logic [4:0] serial0_oe,
  output logic [4:0] serial0_in,
  // two-wire ports: bit0 data, bit1 clock
  input wire logic [1:0] twowire0_out,
  input wire logic [1:0] twowire0_oe,
  output logic [1:0] twowire0_in,
  input wire logic [1:0] twowire1_out,
  input wire logic [1:0] twowire1_oe,
  output logic [1:0] twowire1_in,
  // serial port one: chip select, enable, clock, out, in
  input wire logic [4:0] serial1_out,
  input wire logic [4:0] serial1_oe,
  output logic [4:0] serial1_in,
  // audio data pins: audio0 bits 5..9, audio1 bits 8 and 9
  input wire logic [4:0] audio0_data_pins_out,
  input wire logic [4:0] audio0_data_pins_oe,
  output logic [4:0] audio0_data_pins_in,
  input wire logic [1:0] audio1_data_pins_out,
  input wire logic [1:0] audio1_data_pins_oe,
  output logic [1:0] audio1_data_pins_in,
  // mute output and host interrupt share one pin
  input wire logic audio2_mute_output,
  input wire logic audio2_mute_oe,
  input wire logic host_interrupt_output,
  input wire logic host_interrupt_oe,
  output logic mute_pin_in,
  // memory upper data pins and host address inputs
  input wire logic [15:0] memory_upper_out,
  input wire logic [15:0] memory_upper_oe,
  output logic [15:0] memory_upper_in,
  input wire logic [15:0] memory_pin_i,
  output logic [15:0] memory_pin_o,
  output logic [15:0] memory_pin_oe,
  output logic [15:0] host_address_inputs,
  output logic memory_data_32,
  // mute-input candidates and selections
  input wire logic [MUTE_SRCS-1:0] mute_src_i,
  output logic audio0_mute_input,
  output logic audio1_mute_input,
  output logic audio2_mute_input,
  // timer capture
  input wire logic [5:0] dma_evt,
  output logic [1:0] timer_capture_evt,
  // host port and bridge control
  output logic host_port_enable,
  output logic host_nonmux_mode,
  output logic [15:0] host_addr_upper,
  output logic host_addr_upper_valid,
  output logic internal_bridge_reset
);
  localparam int NP = dcps_pkg::NUM_PINS;
  localparam int NS = dcps_pkg::NUM_SH;
  localparam int SW = NP + dcps_pkg::NUM_MEM + 17 + MUTE_SRCS;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] boot_a;
    logic [7:0] boot_b;
    logic rst_prev;
    logic [2:0] hpc;
    logic [7:0] atop;
    logic [7:0] amid;
    logic [2:0] tsel0;
    logic [2:0] tsel1;
    logic [2:0][dcps_pkg::MUTE_SEL_W-1:0] msel;
    logic bridge;
    logic [1:0] s0opt;
    logic [2:0] s1opt;
    logic [1:0] own;
    logic [NP-1:0] pin_o;
    logic [NP-1:0] pin_oe;
    logic [15:0] mem_o;
    logic [15:0] mem_oe;
    logic [15:0] host_ain;
    logic [1:0] tcap;
    logic [2:0] mute;
  } dcps_top_state_t;

  dcps_top_state_t st_reg;
  dcps_top_state_t st_next;

  logic [SW-1:0] sync_out;
  logic [NP-1:0] pin_s;
  logic [15:0] mem_s;
  logic rst_s;
  logic [7:0] boot_a_s;
  logic [7:0] boot_b_s;
  logic [MUTE_SRCS-1:0] mute_s;
  logic [NP*NS-1:0] oe_raw;
  logic [NP*NS-1:0] out_raw;
  logic [NP-1:0] arb_o;
  logic [NP-1:0] arb_oe;

  // audio data pin limits {audio0, audio1} per serial-one option
  function automatic logic [7:0] audio_limits(input logic [2:0] opt);
    case (opt)
      3'h1: audio_limits = {5'h0B, 3'h4};
      3'h2: audio_limits = {5'h0C, 3'h4};
      3'h3: audio_limits = {5'h0C, 3'h4};
      3'h4: audio_limits = {5'h0D, 3'h4};
      default: audio_limits = {5'h10, 3'h6};
    endcase
  endfunction : audio_limits

  // which sharers the coarse options let drive each pin
  function automatic logic [NP*NS-1:0] permit(
    input logic [1:0] s0, input logic [2:0] s1, input logic [1:0] own);
    logic [4:0] claim;
    permit = '0;
    case (s0)
      2'h2: begin
        for (int p = 0; p < 3; p++) permit[p*NS] = 1'b1;
        permit[dcps_pkg::PIN_S0_CS*NS+1] = 1'b1;
        permit[dcps_pkg::PIN_S0_EN*NS+1] = 1'b1;
      end
      2'h3: begin
        permit[dcps_pkg::PIN_S0_IN*NS] = 1'b1;
        permit[dcps_pkg::PIN_S0_OUT*NS+1] = 1'b1;
        permit[dcps_pkg::PIN_S0_CLK*NS+1] = 1'b1;
        permit[dcps_pkg::PIN_S0_CS*NS+1] = 1'b1;
        permit[dcps_pkg::PIN_S0_EN*NS+1] = 1'b1;
      end
      default: begin
        for (int p = 0; p < 5; p++) permit[p*NS] = 1'b1;
      end
    endcase
    case (s1)
      3'h1: claim = dcps_pkg::S1_CLAIM_OPT1;
      3'h2: claim = dcps_pkg::S1_CLAIM_OPT2;
      3'h3: claim = dcps_pkg::S1_CLAIM_OPT3;
      3'h4: claim = dcps_pkg::S1_CLAIM_OPT4;
      default: claim = 5'h00;
    endcase
    for (int i = 0; i < 5; i++) begin
      if (claim[i]) begin
        permit[(dcps_pkg::PIN_AX5+i)*NS+(i < 3 ? 1 : 2)] = 1'b1;
      end else if (i >= 3 && own[i-3]) begin
        permit[(dcps_pkg::PIN_AX5+i)*NS+1] = 1'b1;
      end else begin
        permit[(dcps_pkg::PIN_AX5+i)*NS] = 1'b1;
      end
    end
    permit[dcps_pkg::PIN_MUTE*NS] = 1'b1;
    permit[dcps_pkg::PIN_MUTE*NS+1] = 1'b1;
  endfunction : permit

  dcps_sync #(
    .W(SW)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({mute_src_i, boot_pins_b, boot_pins_a, ext_reset_n, memory_pin_i, shared_pin_i}),
    .dout(sync_out)
  );

  assign {mute_s, boot_b_s, boot_a_s, rst_s, mem_s, pin_s} = sync_out;

  // request slots, sharer 0 first in priority
  always_comb begin
    oe_raw = '0;
    out_raw = '0;
    for (int p = 0; p < 5; p++) begin
      oe_raw[p*NS] = serial0_oe[p];
      out_raw[p*NS] = serial0_out[p];
      oe_raw[(p+5)*NS] = audio0_data_pins_oe[p];
      out_raw[(p+5)*NS] = audio0_data_pins_out[p];
      oe_raw[(p+5)*NS+(p < 3 ? 1 : 2)] = serial1_oe[p];
      out_raw[(p+5)*NS+(p < 3 ? 1 : 2)] = serial1_out[p];
    end
    oe_raw[dcps_pkg::PIN_S0_OUT*NS+1] = twowire0_oe[0];
    out_raw[dcps_pkg::PIN_S0_OUT*NS+1] = twowire0_out[0];
    oe_raw[dcps_pkg::PIN_S0_CLK*NS+1] = twowire0_oe[1];
    out_raw[dcps_pkg::PIN_S0_CLK*NS+1] = twowire0_out[1];
    oe_raw[dcps_pkg::PIN_S0_EN*NS+1] = twowire1_oe[0];
    out_raw[dcps_pkg::PIN_S0_EN*NS+1] = twowire1_out[0];
    oe_raw[dcps_pkg::PIN_S0_CS*NS+1] = twowire1_oe[1];
    out_raw[dcps_pkg::PIN_S0_CS*NS+1] = twowire1_out[1];
    oe_raw[8*NS+1] = audio1_data_pins_oe[0];
    out_raw[8*NS+1] = audio1_data_pins_out[0];
    oe_raw[9*NS+1] = audio1_data_pins_oe[1];
    out_raw[9*NS+1] = audio1_data_pins_out[1];
    oe_raw[dcps_pkg::PIN_MUTE*NS] = audio2_mute_oe;
    out_raw[dcps_pkg::PIN_MUTE*NS] = audio2_mute_output;
    oe_raw[dcps_pkg::PIN_MUTE*NS+1] = host_interrupt_oe;
    out_raw[dcps_pkg::PIN_MUTE*NS+1] = host_interrupt_output;
  end

  dcps_pin_arb #(
    .NPIN(NP),
    .NSH(NS)
  ) u_arb (
    .drv_oe(oe_raw & permit(st_reg.s0opt, st_reg.s1opt, st_reg.own)),
    .drv_out(out_raw),
    .pin_o(arb_o),
    .pin_oe(arb_oe)
  );

  always_comb begin
    logic setup;
    logic wr;
    logic [31:0] rd;
    logic hit;
    logic nonmux_host_mode_bit;
    logic [7:0] lim;
    setup = psel && !penable;
    wr = psel && penable && st_reg.pready && pwrite;
    rd = 32'h0000_0000;
    hit = 1'b1;
    nonmux_host_mode_bit = st_reg.hpc[dcps_pkg::HPC_NONMUX_HOST_MODE_BIT_BIT];
    lim = audio_limits(st_reg.s1opt);
    st_next = st_reg;

    // read decode in the setup cycle, answer in the first access cycle
    case (paddr)
      dcps_pkg::ADDR_BOOT_A: rd[7:0] = st_reg.boot_a;
      dcps_pkg::ADDR_BOOT_B: rd[7:0] = st_reg.boot_b;
      dcps_pkg::ADDR_HPC: rd[2:0] = st_reg.hpc;
      dcps_pkg::ADDR_ATOP: rd[7:0] = st_reg.atop;
      dcps_pkg::ADDR_AMID: rd[7:0] = st_reg.amid;
      dcps_pkg::ADDR_TCS: begin
        rd[dcps_pkg::TCS_SEL0_LSB+:dcps_pkg::TCS_SEL_W] = st_reg.tsel0;
        rd[dcps_pkg::TCS_SEL1_LSB+:dcps_pkg::TCS_SEL_W] = st_reg.tsel1;
      end
      dcps_pkg::ADDR_MUTE0: rd[dcps_pkg::MUTE_SEL_W-1:0] = st_reg.msel[0];
      dcps_pkg::ADDR_MUTE1: rd[dcps_pkg::MUTE_SEL_W-1:0] = st_reg.msel[1];
      dcps_pkg::ADDR_MUTE2: rd[dcps_pkg::MUTE_SEL_W-1:0] = st_reg.msel[2];
      dcps_pkg::ADDR_BRIDGE: rd[dcps_pkg::BRIDGE_RST_BIT] = st_reg.bridge;
      dcps_pkg::ADDR_PINMUX: begin
        rd[dcps_pkg::PMX_S0_LSB+:2] = st_reg.s0opt;
        rd[dcps_pkg::PMX_S1_LSB+:3] = st_reg.s1opt;
        rd[dcps_pkg::PMX_OWN_LSB+:2] = st_reg.own;
      end
      dcps_pkg::ADDR_STATUS: begin
        rd[dcps_pkg::STS_A0_LSB+:5] = lim[7:3];
        rd[dcps_pkg::STS_A1_LSB+:3] = lim[2:0];
        rd[dcps_pkg::STS_MEM32_BIT] = !nonmux_host_mode_bit;
      end
      default: hit = 1'b0;
    endcase
    st_next.pready = setup;
    st_next.prdata = setup ? rd : 32'h0000_0000;
    st_next.pslverr = setup && !hit;

    if (wr) begin
      case (paddr)
        dcps_pkg::ADDR_HPC: st_next.hpc = pwdata[2:0];
        dcps_pkg::ADDR_ATOP: st_next.atop = pwdata[7:0];
        dcps_pkg::ADDR_AMID: st_next.amid = pwdata[7:0];
        dcps_pkg::ADDR_TCS: begin
          st_next.tsel0 = pwdata[dcps_pkg::TCS_SEL0_LSB+:dcps_pkg::TCS_SEL_W];
          st_next.tsel1 = pwdata[dcps_pkg::TCS_SEL1_LSB+:dcps_pkg::TCS_SEL_W];
        end
        dcps_pkg::ADDR_MUTE0: st_next.msel[0] = pwdata[dcps_pkg::MUTE_SEL_W-1:0];
        dcps_pkg::ADDR_MUTE1: st_next.msel[1] = pwdata[dcps_pkg::MUTE_SEL_W-1:0];
        dcps_pkg::ADDR_MUTE2: begin
          if (!SMALL_VARIANT) begin
            st_next.msel[2] = pwdata[dcps_pkg::MUTE_SEL_W-1:0];
          end
        end
        dcps_pkg::ADDR_BRIDGE: st_next.bridge = pwdata[dcps_pkg::BRIDGE_RST_BIT];
        dcps_pkg::ADDR_PINMUX: begin
          st_next.s0opt = pwdata[dcps_pkg::PMX_S0_LSB+:2];
          st_next.s1opt = pwdata[dcps_pkg::PMX_S1_LSB+:3];
          st_next.own = pwdata[dcps_pkg::PMX_OWN_LSB+:2];
        end
        default: st_next.hpc = st_reg.hpc;
      endcase
    end

    // strap capture on the synchronised rising edge of the reset pin
    st_next.rst_prev = rst_s;
    if (rst_s && !st_reg.rst_prev) begin
      st_next.boot_a = boot_a_s;
      st_next.boot_b = boot_b_s;
    end

    st_next.pin_o = arb_o;
    st_next.pin_oe = arb_oe;

    // memory upper data pins become input-only in non-mux mode
    st_next.mem_o = memory_upper_out;
    st_next.mem_oe = nonmux_host_mode_bit ? 16'h0000 : memory_upper_oe;
    st_next.host_ain = nonmux_host_mode_bit ? mem_s : 16'h0000;

    st_next.tcap[0] = (st_reg.tsel0 < dcps_pkg::NUM_DMA_EVT) && dma_evt[st_reg.tsel0];
    st_next.tcap[1] = (st_reg.tsel1 < dcps_pkg::NUM_DMA_EVT) && dma_evt[st_reg.tsel1];

    for (int k = 0; k < 3; k++) begin
      st_next.mute[k] = (32'(st_reg.msel[k]) < MUTE_SRCS) && mute_s[st_reg.msel[k]];
    end
    if (SMALL_VARIANT) begin
      st_next.mute[2] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.hpc <= dcps_pkg::HPC_RESET;
      st_reg.bridge <= dcps_pkg::BRIDGE_RESET;
      st_reg.s0opt <= dcps_pkg::PMX_S0_RESET;
      st_reg.s1opt <= dcps_pkg::PMX_S1_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign shared_pin_o = st_reg.pin_o;
  assign shared_pin_oe = st_reg.pin_oe;

  // pin levels fan out to every sharer from the synchroniser flops
  assign serial0_in = pin_s[4:0];
  assign twowire0_in = {pin_s[dcps_pkg::PIN_S0_CLK], pin_s[dcps_pkg::PIN_S0_OUT]};
  assign twowire1_in = {pin_s[dcps_pkg::PIN_S0_CS], pin_s[dcps_pkg::PIN_S0_EN]};
  assign serial1_in = pin_s[9:5];
  assign audio0_data_pins_in = pin_s[9:5];
  assign audio1_data_pins_in = pin_s[9:8];
  assign mute_pin_in = pin_s[dcps_pkg::PIN_MUTE];
  assign memory_upper_in = mem_s;

  assign memory_pin_o = st_reg.mem_o;
  assign memory_pin_oe = st_reg.mem_oe;
  assign host_address_inputs = st_reg.host_ain;
  assign memory_data_32 = !st_reg.hpc[dcps_pkg::HPC_NONMUX_HOST_MODE_BIT_BIT];
  assign audio0_mute_input = st_reg.mute[0];
  assign audio1_mute_input = st_reg.mute[1];
  assign audio2_mute_input = st_reg.mute[2];
  assign timer_capture_evt = st_reg.tcap;
  assign host_port_enable = st_reg.hpc[dcps_pkg::HPC_EN_BIT];
  assign host_nonmux_mode = st_reg.hpc[dcps_pkg::HPC_NONMUX_HOST_MODE_BIT_BIT];
  assign host_addr_upper_valid = st_reg.hpc[dcps_pkg::HPC_NONMUX_HOST_MODE_BIT_BIT]
    || st_reg.hpc[dcps_pkg::HPC_SECURE_BIT];
  assign host_addr_upper = host_addr_upper_valid ? {st_reg.atop, st_reg.amid} : 16'h0000;
  assign internal_bridge_reset = st_reg.bridge;
endmodule : dcps_top

// File: logic/dcps_pkg.sv
// device configuration and pin sharing: shared constants
// assumes a 32-bit APB with byte addresses and single-word registers
package dcps_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_BOOT_A = 32'h4000_0000;
  localparam logic [31:0] ADDR_BOOT_B = 32'h4000_0004;
  localparam logic [31:0] ADDR_HPC = 32'h4000_0008;
  localparam logic [31:0] ADDR_ATOP = 32'h4000_000C;
  localparam logic [31:0] ADDR_AMID = 32'h4000_0010;
  localparam logic [31:0] ADDR_TCS = 32'h4000_0014;
  localparam logic [31:0] ADDR_MUTE0 = 32'h4000_0018;
  localparam logic [31:0] ADDR_MUTE1 = 32'h4000_001C;
  localparam logic [31:0] ADDR_MUTE2 = 32'h4000_0020;
  localparam logic [31:0] ADDR_BRIDGE = 32'h4000_0024;
  localparam logic [31:0] ADDR_PINMUX = 32'h4000_0028;
  localparam logic [31:0] ADDR_STATUS = 32'h4000_002C;

  // host_port_config fields
  localparam int HPC_EN_BIT = 0;
  localparam int HPC_NONMUX_HOST_MODE_BIT_BIT = 1;
  localparam int HPC_SECURE_BIT = 2;
  localparam logic [2:0] HPC_RESET = 3'h0;

  // timer_capture_source fields
  localparam int TCS_SEL0_LSB = 0;
  localparam int TCS_SEL1_LSB = 4;
  localparam int TCS_SEL_W = 3;
  localparam logic [2:0] NUM_DMA_EVT = 3'h6;

  // mute select field
  localparam int MUTE_SEL_W = 4;

  // bridge_reset_control field
  localparam int BRIDGE_RST_BIT = 0;
  localparam logic BRIDGE_RESET = 1'b0;

  // pin-mux option register fields and reset options
  localparam int PMX_S0_LSB = 0;
  localparam int PMX_S1_LSB = 4;
  localparam int PMX_OWN_LSB = 8;
  localparam logic [1:0] PMX_S0_RESET = 2'h1;
  localparam logic [2:0] PMX_S1_RESET = 3'h5;

  // status register fields
  localparam int STS_A0_LSB = 0;
  localparam int STS_A1_LSB = 8;
  localparam int STS_MEM32_BIT = 16;

  // serial-port-one claim masks, bit0..4 = chip select, enable, clock, out, in
  localparam logic [4:0] S1_CLAIM_OPT1 = 5'h1F;
  localparam logic [4:0] S1_CLAIM_OPT2 = 5'h1D;
  localparam logic [4:0] S1_CLAIM_OPT3 = 5'h1E;
  localparam logic [4:0] S1_CLAIM_OPT4 = 5'h1C;

  // shared pin indices; sharer 0 has highest output priority
  localparam int PIN_S0_OUT = 0;
  localparam int PIN_S0_IN = 1;
  localparam int PIN_S0_CLK = 2;
  localparam int PIN_S0_CS = 3;
  localparam int PIN_S0_EN = 4;
  localparam int PIN_AX5 = 5;
  localparam int PIN_MUTE = 10;
  localparam int NUM_PINS = 11;
  localparam int NUM_SH = 3;
  localparam int NUM_MEM = 16;

endpackage : dcps_pkg

// File: logic/dcps_sync.sv
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; no bus coherence is implied
`timescale 1ns/1ps
module dcps_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dcps_sync_state_t;

  dcps_sync_state_t s_reg;
  dcps_sync_state_t s_next;

  always_comb begin
    s_next.meta = din;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.stable;
endmodule : dcps_sync

// File: logic/dcps_pin_arb.sv
// output arbiter for a set of shared pins
// assumes request slot p*NSH+s; sharer 0 is the highest priority
`timescale 1ns/1ps
module dcps_pin_arb #(
  parameter int NPIN = 11,
  parameter int NSH = 3
) (
  // per-sharer requests
  input wire logic [NPIN*NSH-1:0] drv_oe,
  input wire logic [NPIN*NSH-1:0] drv_out,
  // resolved pin drive
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe
);
  always_comb begin
    pin_o = '0;
    pin_oe = '0;
    for (int p = 0; p < NPIN; p++) begin
      for (int s = NSH - 1; s >= 0; s--) begin
        if (drv_oe[p*NSH+s]) begin
          pin_oe[p] = 1'b1;
          pin_o[p] = drv_out[p*NSH+s];
        end
      end
    end
  end
endmodule : dcps_pin_arb

// File: tb/dcps_chk.sv
// checker for the configuration bank and shared-pin timing
// assumes it is bound to dcps_top and sees only that module's ports
`timescale 1ns/1ps
module dcps_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // shared pins
  input wire logic [dcps_pkg::NUM_PINS-1:0] shared_pin_i,
  input wire logic [dcps_pkg::NUM_PINS-1:0] shared_pin_o,
  input wire logic [dcps_pkg::NUM_PINS-1:0] shared_pin_oe,
  input wire logic audio2_mute_output,
  input wire logic audio2_mute_oe,
  input wire logic host_interrupt_output,
  input wire logic host_interrupt_oe,
  input wire logic mute_pin_in,
  input wire logic [4:0] serial0_in,
  input wire logic [1:0] twowire0_in,
  // host and memory
  input wire logic host_nonmux_mode,
  input wire logic memory_data_32,
  input wire logic [15:0] memory_pin_oe,
  input wire logic [15:0] host_addr_upper,
  input wire logic host_addr_upper_valid
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_pin_drive: assert property (audio2_mute_oe || host_interrupt_oe |=> shared_pin_oe[10])
    else $error("shared pin not driven");
  chk_pin_idle: assert property (!audio2_mute_oe && !host_interrupt_oe |=> !shared_pin_oe[10])
    else $error("shared pin driven with no request");
  chk_mute_wins: assert property (audio2_mute_oe |=> shared_pin_o[10] == $past(audio2_mute_output))
    else $error("mute output lost priority");
  chk_host_interrupt_output_alone: assert property (!audio2_mute_oe && host_interrupt_oe
    |=> shared_pin_o[10] == $past(host_interrupt_output))
    else $error("host interrupt value not driven");
  chk_fanout_same: assert property ($past(presetn) && $past(presetn, 2)
    |-> {twowire0_in[1], serial0_in[1], twowire0_in[0]} == $past(shared_pin_i[2:0], 2))
    else $error("sharers see different pin levels");
  chk_input_delay: assert property ($past(presetn) && $past(presetn, 2)
    |-> mute_pin_in == $past(shared_pin_i[10], 2))
    else $error("pin input delay wrong");
  chk_mem_width: assert property (memory_data_32 == !host_nonmux_mode)
    else $error("memory width disagrees with host mode");
  chk_mem_input: assert property (host_nonmux_mode && $past(host_nonmux_mode)
    |-> memory_pin_oe == 16'h0000)
    else $error("upper memory pins driven in non-mux mode");
  chk_addr_gate: assert property (!host_addr_upper_valid |-> host_addr_upper == 16'h0000)
    else $error("upper address shown while not valid");
endmodule : dcps_chk

bind dcps_top dcps_chk chk (.*);

// File: tb/dcps_periph_model.sv
// model of the on-chip peripherals that share package pins
// assumes drive_en picks which peripherals turn their pins to outputs
`timescale 1ns/1ps
module dcps_periph_model (
  // bits: s0, tw0, tw1, s1, audio0, audio1, mute, host int, memory
  input wire logic [8:0] drive_en,
  // serial and two-wire ports
  output logic [4:0] serial0_out,
  output logic [4:0] serial0_oe,
  output logic [1:0] twowire0_out,
  output logic [1:0] twowire0_oe,
  output logic [1:0] twowire1_out,
  output logic [1:0] twowire1_oe,
  output logic [4:0] serial1_out,
  output logic [4:0] serial1_oe,
  // audio, mute and host interrupt
  output logic [4:0] audio0_data_pins_out,
  output logic [4:0] audio0_data_pins_oe,
  output logic [1:0] audio1_data_pins_out,
  output logic [1:0] audio1_data_pins_oe,
  output logic audio2_mute_output,
  output logic audio2_mute_oe,
  output logic host_interrupt_output,
  output logic host_interrupt_oe,
  // memory interface
  output logic [15:0] memory_upper_out,
  output logic [15:0] memory_upper_oe
);
  // several peripherals drive one pin only when the bench asks
  assign serial0_out = 5'h15;
  assign serial0_oe = {5{drive_en[0]}};
  assign twowire0_out = 2'h2;
  assign twowire0_oe = {2{drive_en[1]}};
  assign twowire1_out = 2'h2;
  assign twowire1_oe = {2{drive_en[2]}};
  assign serial1_out = 5'h0A;
  assign serial1_oe = {5{drive_en[3]}};
  assign audio0_data_pins_out = 5'h13;
  assign audio0_data_pins_oe = {5{drive_en[4]}};
  assign audio1_data_pins_out = 2'h1;
  assign audio1_data_pins_oe = {2{drive_en[5]}};
  assign audio2_mute_output = 1'h1;
  assign audio2_mute_oe = drive_en[6];
  assign host_interrupt_output = !drive_en[6];
  assign host_interrupt_oe = drive_en[7];
  assign memory_upper_out = 16'hBEEF;
  assign memory_upper_oe = {16{drive_en[8]}};
endmodule : dcps_periph_model

// File: tb/device_config_pin_sharing_test.sv
// testbench for the configuration bank and shared-pin logic
// assumes dcps_top with default parameters and the peripheral model
`timescale 1ns/1ps
module device_config_pin_sharing_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_reset_n;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [7:0] boot_pins_a, boot_pins_b;
  logic [dcps_pkg::NUM_PINS-1:0] shared_pin_i, shared_pin_o, shared_pin_oe;
  logic [4:0] serial0_out, serial0_oe, serial0_in, serial1_out, serial1_oe, serial1_in;
  logic [4:0] audio0_data_pins_out, audio0_data_pins_oe, audio0_data_pins_in;
  logic [1:0] twowire0_out, twowire0_oe, twowire0_in, twowire1_out, twowire1_oe;
  logic [1:0] twowire1_in, audio1_data_pins_out, audio1_data_pins_oe;
  logic [1:0] audio1_data_pins_in, timer_capture_evt;
  logic audio2_mute_output, audio2_mute_oe, host_interrupt_output, host_interrupt_oe;
  logic [15:0] memory_upper_out, memory_upper_oe, memory_upper_in, memory_pin_i;
  logic [15:0] memory_pin_o, memory_pin_oe, host_address_inputs, host_addr_upper, mute_src_i;
  logic memory_data_32, audio0_mute_input, audio1_mute_input, audio2_mute_input;
  logic host_port_enable, host_nonmux_mode, host_addr_upper_valid, internal_bridge_reset;
  logic mute_pin_in, e;
  logic [5:0] dma_evt;
  logic [8:0] drive_en;
  int fails, checked;
  logic [4:0] s1m [1:5] = '{5'h1F, 5'h1D, 5'h1E, 5'h1C, 5'h00};
  logic [4:0] a0m [1:5] = '{5'h0B, 5'h0C, 5'h0C, 5'h0D, 5'h10};
  logic [4:0] s0v [1:3] = '{5'h15, 5'h0D, 5'h0C};
  localparam logic [10:0] PAT = 11'h5A6;

  dcps_top dut (.*);
  dcps_periph_model peers (.*);

  always #2 pclk = ~pclk;

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  task check(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  task tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 16) begin
      fails++;
      tally_and_finish();
    end
  endtask : apb

  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    check($sformatf("read %h", a), r, x);
  endtask : rd

  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ext_reset_n = 1'h1;
    boot_pins_a = 8'hA5;
    boot_pins_b = 8'h3C;
    shared_pin_i = '0;
    memory_pin_i = 16'h0;
    mute_src_i = 16'h0;
    dma_evt = 6'h0;
    drive_en = 9'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    tick(6);
    for (int i = 0; i < 11; i++) begin
      rd(dcps_pkg::ADDR_BOOT_A + 4 * i, i == 0 ? 32'hA5 : i == 1 ? 32'h3C : i == 10 ? 32'h51 : 32'h0);
    end
    wr(dcps_pkg::ADDR_BOOT_A, 32'h0);
    check("read-only error", e, 1'h0);
    apb(1'h1, 32'h4000_0030, 32'h1);
    check("unmapped error", e, 1'h1);
    boot_pins_a <= 8'h5A;
    ext_reset_n <= 1'h0;
    tick(4);
    ext_reset_n <= 1'h1;
    tick(8);
    rd(dcps_pkg::ADDR_BOOT_A, 32'h5A);
    drive_en <= 9'h008;
    for (int o = 1; o <= 5; o++) begin
      wr(dcps_pkg::ADDR_PINMUX, 32'h1 | (o << 4));
      tick(2);
      check("s1 oe", shared_pin_oe[9:5], s1m[o]);
      check("s1 out", shared_pin_o[9:5], s1m[o] & 5'h0A);
      rd(dcps_pkg::ADDR_STATUS, {15'h0, 1'h1, 5'h0, o == 5 ? 3'h6 : 3'h4, 3'h0, a0m[o]});
    end
    drive_en <= 9'h020;
    wr(dcps_pkg::ADDR_PINMUX, 32'h51);
    tick(2);
    check("owner audio0 oe", shared_pin_oe[9:8], 2'h0);
    wr(dcps_pkg::ADDR_PINMUX, 32'h351);
    tick(2);
    check("owner audio1 oe", shared_pin_oe[9:8], 2'h3);
    check("owner audio1 out", shared_pin_o[9:8], 2'h1);
    drive_en <= 9'h007;
    for (int o = 1; o <= 3; o++) begin
      wr(dcps_pkg::ADDR_PINMUX, 32'h50 | o);
      tick(2);
      check("s0 oe", shared_pin_oe[4:0], 5'h1F);
      check("s0 out", shared_pin_o[4:0], s0v[o]);
    end
    drive_en <= 9'h0C0;
    tick(2);
    check("mute over host int", shared_pin_o[10], 1'h1);
    drive_en <= 9'h080;
    tick(2);
    check("host int alone", shared_pin_o[10], 1'h1);
    wr(dcps_pkg::ADDR_HPC, 32'h3);
    drive_en <= 9'h100;
    memory_pin_i <= 16'h5AC3;
    wr(dcps_pkg::ADDR_ATOP, 32'h12);
    wr(dcps_pkg::ADDR_AMID, 32'h34);
    tick(4);
    check("host enable", host_port_enable, 1'h1);
    check("non-mux", {host_nonmux_mode, memory_data_32}, 2'h2);
    check("mem oe off", memory_pin_oe, 16'h0);
    check("host addr in", {host_address_inputs, memory_upper_in}, {2{16'h5AC3}});
    check("upper addr", host_addr_upper, 16'h1234);
    wr(dcps_pkg::ADDR_HPC, 32'h1);
    tick(2);
    check("upper addr off", host_addr_upper, 16'h0);
    check("mem oe on", memory_pin_oe, 16'hFFFF);
    check("mem out", memory_pin_o, 16'hBEEF);
    wr(dcps_pkg::ADDR_HPC, 32'h5);
    tick(2);
    check("secure addr", {host_addr_upper_valid, host_addr_upper}, 17'h11234);
    rd(dcps_pkg::ADDR_HPC, 32'h5);
    shared_pin_i <= PAT;
    tick(4);
    check("s0 in", serial0_in, PAT[4:0]);
    check("s1 in", serial1_in, PAT[9:5]);
    check("a0 in", audio0_data_pins_in, PAT[9:5]);
    check("tw1 in", twowire1_in, {PAT[3], PAT[4]});
    check("a1 in", audio1_data_pins_in, {PAT[9], PAT[8]});
    check("tw0 mute in", {twowire0_in, mute_pin_in}, {PAT[2], PAT[0], PAT[10]});
    mute_src_i <= 16'h0100;
    wr(dcps_pkg::ADDR_MUTE0, 32'h8);
    wr(dcps_pkg::ADDR_MUTE1, 32'h3);
    wr(dcps_pkg::ADDR_MUTE2, 32'h8);
    tick(4);
    check("mute0", audio0_mute_input, 1'h1);
    check("mute1", audio1_mute_input, 1'h0);
    check("mute2", audio2_mute_input, 1'h1);
    wr(dcps_pkg::ADDR_TCS, 32'h52);
    for (int k = 0; k < 6; k++) begin
      dma_evt <= 6'h1 << k;
      tick(1);
      dma_evt <= 6'h0;
      tick(1);
      check("capture", timer_capture_evt, {k == 5, k == 2});
    end
    wr(dcps_pkg::ADDR_BRIDGE, 32'h1);
    tick(2);
    check("bridge held", internal_bridge_reset, 1'h1);
    wr(dcps_pkg::ADDR_BRIDGE, 32'h0);
    tick(2);
    check("bridge free", internal_bridge_reset, 1'h0);
    tally_and_finish();
  end
endmodule : device_config_pin_sharing_test
